// [cfg_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Configuration host: EEPROM loader or bus host writing single bytes
module cfg_host_model (
    // Clock
    input wire logic clk_sys_i,
    // Access port toward the register bank
    output logic [7:0] addr_o,
    output logic wr_o,
    output logic [7:0] wdata_o,
    input wire logic [7:0] rd_data_i
);
    // Idle values; data is scrambled so a stale byte never looks valid
    initial begin
        addr_o = 8'h00;
        wr_o = 1'b0;
        wdata_o = 8'ha5;
    end

    // One-cycle strobe, then data flipped once released
    task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr_o <= a;
        wr_o <= 1'b1;
        wdata_o <= d;
        @(posedge clk_sys_i);
        wr_o <= 1'b0;
        wdata_o <= ~d;
    endtask

    // Address held; read data is registered one edge after the address
    task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        addr_o <= a;
        @(posedge clk_sys_i);
        @(posedge clk_sys_i);
        #1;
        d = rd_data_i;
    endtask
endmodule

`default_nettype wire

// [hub_cfg_defs.svh]
`ifndef HUB_CFG_DEFS_SVH
`define HUB_CFG_DEFS_SVH

// ==========================================================
// Register offsets
`define CHG_CFG_ADDR 8'h0a
`define SWAP_CTRL_ADDR 8'h0b

// ==========================================================
// Charging and power configuration fields
`define CHG_UNLOCK_BIT 6
`define PWR_POL_BIT 5
`define DIV_SEL_BIT 4
`define CHG_SPARE_MSB 3
`define CHG_SPARE_LSB 2
`define AUTO_DIS_BIT 1
`define CHG_CFG_RESET 8'h10

// ==========================================================
// Port swap control fields
`define SWAP_UNLOCK_BIT 7
`define SWAP_FIELD_MSB 4
`define SWAP_CTRL_RESET 8'h00

// ==========================================================
// Outputs and strap timing
`define PWR_OUT_RESET 4'hf
`define STRAP_SETTLE 2'h2

`endif

// [hub_cfg_pkg.sv]
`default_nettype none

package hub_cfg_pkg;

    // Charging behaviour offered on one downstream port
    typedef enum logic [1:0] {
        CHG_OFF,
        CHG_CDP,
        CHG_DCP,
        CHG_AUTO
    } charge_mode_t;

    // One configuration byte
    typedef logic [7:0] cfg_byte_t;

endpackage

`default_nettype wire

// [hub_charging_polarity_config_regs.sv]
`timescale 1ns/1ps
`default_nettype none
`include "hub_cfg_defs.svh"

module hub_charging_polarity_config_regs #(
    parameter int NUM_DS_PORTS = 4
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Configuration access from EEPROM loader or SMBus host
    input wire logic [7:0] cfg_addr_i,
    input wire logic cfg_wr_i,
    input wire logic [7:0] cfg_wdata_i,
    output logic [7:0] cfg_rd_data_o,
    // One-time-programmable defaults
    input wire logic otp_high_current_divider_select_i,
    input wire logic [4:0] otp_port_dm_dp_swap_i,
    // Strap pins
    input wire logic power_polarity_strap_pin_i,
    input wire logic auto_charge_strap_pin_i,
    // Hub status
    input wire logic upstream_connected_i,
    input wire logic [3:0] charge_port_enable_i,
    input wire logic [3:0] port_power_request_i,
    // Steering outputs
    output logic [3:0] power_switch_enable_out_o,
    output hub_cfg_pkg::charge_mode_t [3:0] charge_mode_o,
    output logic divider_mode_three_o,
    output logic [4:0] port_dm_dp_swap_o
);

    // ==========================================================
    // Elaboration check: the field layout is fixed at four ports
    if (NUM_DS_PORTS != 4) begin : g_bad_ports
        $error("Register layout serves exactly four downstream ports");
    end

    // ==========================================================
    // Strap capture
    logic [1:0] strap_val; // [0] polarity, [1] auto disable
    logic strap_cap; // Pulse when strap_val is valid

    strap_capture #(
        .WIDTH(2)
    ) u_strap (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .pins_i({auto_charge_strap_pin_i, power_polarity_strap_pin_i}),
        .value_o(strap_val),
        .capture_o(strap_cap)
    );

    // ==========================================================
    // Configuration registers
    hub_cfg_pkg::cfg_byte_t chg_q; // Charging and power configuration
    hub_cfg_pkg::cfg_byte_t chg_d;
    hub_cfg_pkg::cfg_byte_t swap_q; // Port swap control
    hub_cfg_pkg::cfg_byte_t swap_d;
    logic wr_chg; // Write hits charging register
    logic wr_swap; // Write hits swap register
    logic div_sel; // Effective divider select
    logic [4:0] swap_eff; // Effective swap bits

    assign wr_chg = cfg_wr_i && (cfg_addr_i == `CHG_CFG_ADDR);
    assign wr_swap = cfg_wr_i && (cfg_addr_i == `SWAP_CTRL_ADDR);

    // Locked fields mirror OTP instead of the stored copy
    assign div_sel = chg_q[`CHG_UNLOCK_BIT] ? chg_q[`DIV_SEL_BIT]
                                            : otp_high_current_divider_select_i;
    assign swap_eff = swap_q[`SWAP_UNLOCK_BIT] ? swap_q[`SWAP_FIELD_MSB:0]
                                               : otp_port_dm_dp_swap_i;

    // Next register values; a write in the capture cycle wins over the strap
    always_comb begin
        chg_d = chg_q;
        swap_d = swap_q;
        if (strap_cap) begin
            chg_d[`PWR_POL_BIT] = strap_val[0];
            chg_d[`AUTO_DIS_BIT] = strap_val[1];
        end
        if (wr_chg) begin
            chg_d[`CHG_UNLOCK_BIT] = cfg_wdata_i[`CHG_UNLOCK_BIT];
            chg_d[`PWR_POL_BIT] = cfg_wdata_i[`PWR_POL_BIT];
            chg_d[`CHG_SPARE_MSB:`CHG_SPARE_LSB] = cfg_wdata_i[`CHG_SPARE_MSB:`CHG_SPARE_LSB];
            chg_d[`AUTO_DIS_BIT] = cfg_wdata_i[`AUTO_DIS_BIT];
            // The unlock in the same write already opens the select
            if (cfg_wdata_i[`CHG_UNLOCK_BIT]) begin
                chg_d[`DIV_SEL_BIT] = cfg_wdata_i[`DIV_SEL_BIT];
            end
        end
        if (wr_swap) begin
            swap_d[`SWAP_UNLOCK_BIT] = cfg_wdata_i[`SWAP_UNLOCK_BIT];
            // Locked swap bits keep their value
            if (cfg_wdata_i[`SWAP_UNLOCK_BIT]) begin
                swap_d[`SWAP_FIELD_MSB:0] = cfg_wdata_i[`SWAP_FIELD_MSB:0];
            end
        end
    end

    // Configuration registers; reserved bits are never loaded
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            chg_q <= `CHG_CFG_RESET;
            swap_q <= `SWAP_CTRL_RESET;
        end else begin
            chg_q <= chg_d;
            swap_q <= swap_d;
        end
    end

    // ==========================================================
    // Read path, one cycle behind the address
    hub_cfg_pkg::cfg_byte_t rd_d;
    hub_cfg_pkg::cfg_byte_t rd_q;

    // Assemble read byte; reserved bits and unmapped offsets give zero
    always_comb begin
        rd_d = 8'h00;
        case (cfg_addr_i)
            `CHG_CFG_ADDR: begin
                rd_d[`CHG_UNLOCK_BIT] = chg_q[`CHG_UNLOCK_BIT];
                rd_d[`PWR_POL_BIT] = chg_q[`PWR_POL_BIT];
                rd_d[`DIV_SEL_BIT] = div_sel;
                rd_d[`CHG_SPARE_MSB:`CHG_SPARE_LSB] = chg_q[`CHG_SPARE_MSB:`CHG_SPARE_LSB];
                rd_d[`AUTO_DIS_BIT] = chg_q[`AUTO_DIS_BIT];
            end
            `SWAP_CTRL_ADDR: begin
                rd_d[`SWAP_UNLOCK_BIT] = swap_q[`SWAP_UNLOCK_BIT];
                rd_d[`SWAP_FIELD_MSB:0] = swap_eff;
            end
            default: begin
                rd_d = 8'h00;
            end
        endcase
    end

    // Read data register
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_q <= 8'h00;
        end else begin
            rd_q <= rd_d;
        end
    end

    assign cfg_rd_data_o = rd_q;

    // ==========================================================
    // Port steering outputs
    logic [3:0] pwr_d;
    logic [3:0] pwr_q;
    hub_cfg_pkg::charge_mode_t [3:0] mode_d;
    hub_cfg_pkg::charge_mode_t [3:0] mode_q;
    logic div3_d;
    logic div3_q;
    logic [4:0] swap_out_q;

    // Next steering values from the configuration and hub status
    always_comb begin
        // Polarity bit picks the active level of every enable
        pwr_d = chg_q[`PWR_POL_BIT] ? port_power_request_i : ~port_power_request_i;
        div3_d = div_sel;
        for (int i = 0; i < 4; i++) begin
            if (!charge_port_enable_i[i]) begin
                mode_d[i] = hub_cfg_pkg::CHG_OFF;
            end else if (upstream_connected_i) begin
                mode_d[i] = hub_cfg_pkg::CHG_CDP;
            end else if (!chg_q[`AUTO_DIS_BIT]) begin
                mode_d[i] = hub_cfg_pkg::CHG_AUTO;
            end else begin
                // Unconnected and restricted: only the dedicated mode fits
                mode_d[i] = hub_cfg_pkg::CHG_DCP;
            end
        end
    end

    // Steering registers; power enables start deasserted for active low
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pwr_q <= `PWR_OUT_RESET;
            mode_q <= '{4{hub_cfg_pkg::CHG_OFF}};
            div3_q <= 1'b0;
            swap_out_q <= 5'h00;
        end else begin
            pwr_q <= pwr_d;
            mode_q <= mode_d;
            div3_q <= div3_d;
            swap_out_q <= swap_eff;
        end
    end

    assign power_switch_enable_out_o = pwr_q;
    assign charge_mode_o = mode_q;
    assign divider_mode_three_o = div3_q;
    assign port_dm_dp_swap_o = swap_out_q;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);

    // Write that opens the charging unlock and loads the select together
    sequence chg_unlock_wr_s;
        wr_chg && cfg_wdata_i[`CHG_UNLOCK_BIT];
    endsequence

    // Followed by a quiet read of the same register
    sequence chg_quiet_read_s;
        !cfg_wr_i && (cfg_addr_i == `CHG_CFG_ADDR);
    endsequence

    rsvd_read_zero_a: assert property (
        (cfg_addr_i == `CHG_CFG_ADDR || cfg_addr_i == `SWAP_CTRL_ADDR)
        |=> (cfg_rd_data_o[7] == 1'b0 || $past(cfg_addr_i) == `SWAP_CTRL_ADDR)
            && cfg_rd_data_o[0] == ($past(cfg_addr_i) == `SWAP_CTRL_ADDR
                                    && cfg_rd_data_o[0])
            && ($past(cfg_addr_i) == `CHG_CFG_ADDR || cfg_rd_data_o[6:5] == 2'h0))
        else $error("Reserved bit read back nonzero");

    div_lock_mirror_a: assert property (
        (cfg_addr_i == `CHG_CFG_ADDR && !chg_q[`CHG_UNLOCK_BIT])
        |=> cfg_rd_data_o[`DIV_SEL_BIT] == $past(otp_high_current_divider_select_i))
        else $error("Locked divider select does not mirror OTP");

    unlock_same_write_a: assert property (
        chg_unlock_wr_s ##1 chg_quiet_read_s
        |=> cfg_rd_data_o[`DIV_SEL_BIT] == $past(cfg_wdata_i[`DIV_SEL_BIT], 2))
        else $error("Select not applied with unlock write");

    strap_capture_a: assert property (
        (strap_cap && !wr_chg)
        |=> chg_q[`PWR_POL_BIT] == $past(strap_val[0])
            && chg_q[`AUTO_DIS_BIT] == $past(strap_val[1]))
        else $error("Strap not captured into configuration");

    pwr_polarity_a: assert property (
        (!chg_q[`PWR_POL_BIT] && $stable(chg_q[`PWR_POL_BIT]) && port_power_request_i == 4'hf)
        |=> power_switch_enable_out_o == 4'h0)
        else $error("Active low power enable not driven low");

    div_three_a: assert property (
        (chg_q[`CHG_UNLOCK_BIT] && chg_q[`DIV_SEL_BIT]) |=> divider_mode_three_o)
        else $error("Divider mode three not selected");

    auto_mode_a: assert property (
        (!upstream_connected_i && charge_port_enable_i[0])
        |=> charge_mode_o[0] == ($past(chg_q[`AUTO_DIS_BIT]) ? hub_cfg_pkg::CHG_DCP
                                                          : hub_cfg_pkg::CHG_AUTO))
        else $error("Unconnected charging mode wrong");

    cdp_connected_a: assert property (
        (upstream_connected_i && charge_port_enable_i[3]) |=> charge_mode_o[3] == hub_cfg_pkg::CHG_CDP)
        else $error("Connected upstream did not give CDP");

    swap_locked_a: assert property (
        (wr_swap && !cfg_wdata_i[`SWAP_UNLOCK_BIT])
        |=> swap_q[`SWAP_FIELD_MSB:0] == $past(swap_q[`SWAP_FIELD_MSB:0]))
        else $error("Locked swap bits were written");

    swap_mirror_a: assert property (
        (!swap_q[`SWAP_UNLOCK_BIT]) |=> port_dm_dp_swap_o == $past(otp_port_dm_dp_swap_i))
        else $error("Locked swap outputs do not follow OTP");

endmodule

`default_nettype wire

// [hub_charging_polarity_config_regs_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Testbench top
module hub_charging_polarity_config_regs_tb_top;
    // Design inputs
    logic clk_sys_i;
    logic reset_n_i;
    logic [7:0] cfg_addr_i;
    logic cfg_wr_i;
    logic [7:0] cfg_wdata_i;
    logic otp_high_current_divider_select_i;
    logic [4:0] otp_port_dm_dp_swap_i;
    logic power_polarity_strap_pin_i;
    logic auto_charge_strap_pin_i;
    logic upstream_connected_i;
    logic [3:0] charge_port_enable_i;
    logic [3:0] port_power_request_i;
    // Design outputs
    logic [7:0] cfg_rd_data_o;
    logic [3:0] power_switch_enable_out_o;
    hub_cfg_pkg::charge_mode_t [3:0] charge_mode_o;
    logic divider_mode_three_o;
    logic [4:0] port_dm_dp_swap_o;
    // Score
    int fail_count = 0;
    int checks_done = 0;

    // Clock at 40 MHz
    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    cfg_host_model host_u (
        .clk_sys_i(clk_sys_i),
        .addr_o(cfg_addr_i),
        .wr_o(cfg_wr_i),
        .wdata_o(cfg_wdata_i),
        .rd_data_i(cfg_rd_data_o)
    );

    hub_charging_polarity_config_regs #(.NUM_DS_PORTS(4)) dut_u (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .cfg_addr_i(cfg_addr_i),
        .cfg_wr_i(cfg_wr_i),
        .cfg_wdata_i(cfg_wdata_i),
        .cfg_rd_data_o(cfg_rd_data_o),
        .otp_high_current_divider_select_i(otp_high_current_divider_select_i),
        .otp_port_dm_dp_swap_i(otp_port_dm_dp_swap_i),
        .power_polarity_strap_pin_i(power_polarity_strap_pin_i),
        .auto_charge_strap_pin_i(auto_charge_strap_pin_i),
        .upstream_connected_i(upstream_connected_i),
        .charge_port_enable_i(charge_port_enable_i),
        .port_power_request_i(port_power_request_i),
        .power_switch_enable_out_o(power_switch_enable_out_o),
        .charge_mode_o(charge_mode_o),
        .divider_mode_three_o(divider_mode_three_o),
        .port_dm_dp_swap_o(port_dm_dp_swap_o)
    );

    // ==========================================
    // Compare and access tasks
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_mode(input hub_cfg_pkg::charge_mode_t got,
                            input hub_cfg_pkg::charge_mode_t exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Read a register through the host and compare
    task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host_u.read_byte(a, d);
        cmp_byte(d, exp);
    endtask

    // Expected mode per port worked out from enable, link state and auto bit
    task automatic chk_modes(input logic auto_dis);
        repeat (2) @(posedge clk_sys_i);
        #1;
        for (int i = 0; i < 4; i++) begin
            if (!charge_port_enable_i[i]) begin
                cmp_mode(charge_mode_o[i], hub_cfg_pkg::CHG_OFF);
            end else if (upstream_connected_i) begin
                cmp_mode(charge_mode_o[i], hub_cfg_pkg::CHG_CDP);
            end else if (!auto_dis) begin
                cmp_mode(charge_mode_o[i], hub_cfg_pkg::CHG_AUTO);
            end else begin
                cmp_mode(charge_mode_o[i], hub_cfg_pkg::CHG_DCP);
            end
        end
    endtask

    // Verdict and end of run
    task automatic conclude();
        $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Watchdog: the tests need about 95 cycles, so 800 is ample
    initial begin
        #20000;
        fail_count++;
        conclude();
    end

    // ==========================================
    // Main sequence
    initial begin
        reset_n_i = 1'b0;
        otp_high_current_divider_select_i = 1'b0;
        otp_port_dm_dp_swap_i = 5'h15;
        power_polarity_strap_pin_i = 1'b1;
        auto_charge_strap_pin_i = 1'b0;
        upstream_connected_i = 1'b0;
        // Port 2 left without charging so the off mode is seen too
        charge_port_enable_i = 4'hb;
        port_power_request_i = 4'h5;
        repeat (6) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        repeat (5) @(posedge clk_sys_i);
        // Straps captured, select mirrors the fuse value
        chk_reg(8'h0a, 8'h20);
        cmp_byte({4'h0, power_switch_enable_out_o}, 8'h05);
        chk_modes(1'b0);
        // Locked select ignored, polarity and auto bit overwritten
        host_u.write_byte(8'h0a, 8'h9f);
        chk_reg(8'h0a, 8'h0e);
        cmp_byte({4'h0, power_switch_enable_out_o}, 8'h0a);
        cmp_byte({7'h0, divider_mode_three_o}, 8'h00);
        chk_modes(1'b1);
        @(posedge clk_sys_i);
        upstream_connected_i <= 1'b1;
        chk_modes(1'b1);
        // Unlock and select in one write, reserved bits dropped
        host_u.write_byte(8'h0a, 8'hf1);
        chk_reg(8'h0a, 8'h70);
        cmp_byte({7'h0, divider_mode_three_o}, 8'h01);
        chk_modes(1'b0);
        @(posedge clk_sys_i);
        upstream_connected_i <= 1'b0;
        chk_modes(1'b0);
        // Relock: select follows the fuse again
        host_u.write_byte(8'h0a, 8'h22);
        chk_reg(8'h0a, 8'h22);
        cmp_byte({7'h0, divider_mode_three_o}, 8'h00);
        @(posedge clk_sys_i);
        otp_high_current_divider_select_i <= 1'b1;
        chk_reg(8'h0a, 8'h32);
        cmp_byte({7'h0, divider_mode_three_o}, 8'h01);
        // Swap register: locked mirror, unlock, relock
        chk_reg(8'h0b, 8'h15);
        cmp_byte({3'h0, port_dm_dp_swap_o}, 8'h15);
        host_u.write_byte(8'h0b, 8'h0f);
        chk_reg(8'h0b, 8'h15);
        host_u.write_byte(8'h0b, 8'hff);
        chk_reg(8'h0b, 8'h9f);
        cmp_byte({3'h0, port_dm_dp_swap_o}, 8'h1f);
        host_u.write_byte(8'h0b, 8'h8a);
        chk_reg(8'h0b, 8'h8a);
        cmp_byte({3'h0, port_dm_dp_swap_o}, 8'h0a);
        host_u.write_byte(8'h0b, 8'h00);
        chk_reg(8'h0b, 8'h15);
        // Unmapped offset neither stores nor disturbs
        host_u.write_byte(8'h0c, 8'hff);
        chk_reg(8'h0c, 8'h00);
        chk_reg(8'h0a, 8'h32);
        // Second reset with both straps flipped and every port asking for power
        @(posedge clk_sys_i);
        power_polarity_strap_pin_i <= 1'b0;
        auto_charge_strap_pin_i <= 1'b1;
        port_power_request_i <= 4'hf;
        reset_n_i <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        repeat (5) @(posedge clk_sys_i);
        // Fuse select is still 1, so bit 4 reads 1 while locked
        chk_reg(8'h0a, 8'h12);
        cmp_byte({4'h0, power_switch_enable_out_o}, 8'h00);
        cmp_byte({3'h0, port_dm_dp_swap_o}, 8'h15);
        chk_modes(1'b1);
        conclude();
    end
endmodule

`default_nettype wire

// [strap_capture.sv]
`timescale 1ns/1ps
`default_nettype none
`include "hub_cfg_defs.svh"

module strap_capture #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Strap pins, asynchronous to the clock
    input wire logic [WIDTH-1:0] pins_i,
    // Sampled straps and their one-cycle capture strobe
    output logic [WIDTH-1:0] value_o,
    output logic capture_o
);

    // ==========================================================
    // Elaboration check
    if (WIDTH < 1) begin : g_bad_width
        $error("strap_capture needs at least one pin");
    end

    logic [WIDTH-1:0] sync1_q; // First stage, read only by sync2_q
    logic [WIDTH-1:0] sync2_q; // Stable copy of the pins
    logic [1:0] cnt_q; // Cycles since reset release, saturates
    logic [1:0] cnt_d;

    // ==========================================================
    // Settling counter: the pins are only trusted once both stages refilled
    always_comb begin
        cnt_d = cnt_q;
        if (cnt_q <= `STRAP_SETTLE) begin
            cnt_d = cnt_q + 2'h1;
        end
    end

    // Synchroniser and counter registers
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
            cnt_q <= 2'h0;
        end else begin
            sync1_q <= pins_i;
            sync2_q <= sync1_q;
            cnt_q <= cnt_d;
        end
    end

    // One pulse, two edges after release, never again until next reset
    assign capture_o = (cnt_q == `STRAP_SETTLE);
    assign value_o = sync2_q;

endmodule

`default_nettype wire
